// File: rtl/adcs_pkg.sv
// package: register indices, field layout, reset values and types of the converter register set
package adcs_pkg;

	// ==========================================================================
	// register indices (byte address = 4 * index)
	localparam logic [11:0] IDX_REFERENCE_SELECT   = 12'h0f53;
	localparam logic [11:0] IDX_ACQUISITION_TIME   = 12'h0f57;
	localparam logic [11:0] IDX_EXTRA_SAMPLE_CAP   = 12'h0f58;
	localparam logic [11:0] IDX_PRECHARGE_TIME     = 12'h0f59;
	localparam logic [11:0] IDX_POS_CHANNEL_SELECT = 12'h0f5a;
	localparam logic [11:0] IDX_PREVIOUS_RESULT    = 12'h0f5c;
	localparam logic [11:0] IDX_CONVERSION_RESULT  = 12'h0f5e;
	localparam logic [11:0] IDX_REPEAT_THRESHOLD   = 12'h0f61;
	localparam logic [11:0] IDX_REPEAT_COUNTER     = 12'h0f62;
	localparam logic [11:0] IDX_FILTER_OUTPUT      = 12'h0f6d;
	localparam logic [11:0] IDX_COMPUTE_CONTROL    = 12'h0f70;
	localparam logic [11:0] IDX_SEQUENCE_STATUS    = 12'h0f71;

	// ==========================================================================
	// field positions
	localparam int NEG_REF_BIT      = 4;
	localparam int POS_REF_LSB      = 0;
	localparam int CHANNEL_W        = 6;
	localparam int CAP_W            = 5;
	localparam int CTRL_MODE_LSB    = 0;
	localparam int CTRL_CLEAR_BIT   = 3;
	localparam int CTRL_SHIFT_LSB   = 4;
	localparam int CTRL_PREV_BIT    = 7;
	localparam int CTRL_JUSTIFY_BIT = 8;
	localparam int CTRL_GO_BIT      = 9;

	// ==========================================================================
	// reset values
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_WORD   = 16'h0000;
	localparam logic [15:0] LSB_WEIGHT = 16'h0001;
	localparam logic [7:0]  CNT_ONE    = 8'h01;

	// ==========================================================================
	// encodings
	localparam logic [1:0] PREF_SUPPLY   = 2'h0;
	localparam logic [1:0] PREF_RESERVED = 2'h1;
	localparam logic [1:0] PREF_EXTERNAL = 2'h2;
	localparam logic [1:0] PREF_FIXED    = 2'h3;

	typedef enum logic [2:0] {
		MODE_BASIC      = 3'h0,
		MODE_ACCUMULATE = 3'h1,
		MODE_AVERAGE    = 3'h2,
		MODE_BURST      = 3'h3,
		MODE_LOWPASS    = 3'h4
	} adcs_mode_t;

	// sequencer phase as shown in the status register
	localparam logic [2:0] PH_IDLE      = 3'h0;
	localparam logic [2:0] PH_PRECHARGE = 3'h1;
	localparam logic [2:0] PH_ACQUIRE   = 3'h2;
	localparam logic [2:0] PH_CONVERT   = 3'h3;

	// ==========================================================================
	// analog front-end settings carried to the converter core
	typedef struct packed {
		logic                 neg_ref_select;
		logic [1:0]           pos_ref_select;
		logic [CHANNEL_W-1:0] pos_channel_select;
		logic [CAP_W-1:0]     extra_cap_pf;
	} adcs_analog_cfg_t;

	// sequencer strobes to the converter core
	typedef struct packed {
		logic precharge;
		logic acquire;
		logic convert_start;
	} adcs_core_ctl_t;

endpackage

// File: rtl/adcs_regs.sv
// module: register set, conversion sequencer and computation for the 10-bit converter
// ============================================================================
// What this block does
// - negative reference bit picks external low reference pin when set, ground when clear
// - positive reference field: 11 fixed reference, 10 external pin, 00 supply, 01 reserved
// - six-bit channel field picks the analog input on the positive side
// - precharge field 1..255 gives a precharge phase of that many converter clocks
// - precharge field zero removes the precharge phase
// - nonzero acquisition field gives an acquisition phase of that many converter clocks
// - acquisition field zero skips the acquisition phase
// - five-bit capacitance field adds that many picofarads, zero adds none
// - repeat threshold sets the count at which the threshold check fires
// - repeat counter counts triggers before the check, software reads and writes it
// - threshold and counter act only in lowpass, burst average and average modes
// - accumulating modes show the accumulator shifted right by the shift amount
// - lowpass mode shows the lowpass filter output
// - filter output is 16-bit read-only, high and low bytes, resets to zero
// - right justified: high byte holds two upper bits, low byte eight lower bits
// - left justified: high byte upper eight bits, low byte two bits at top
// - result register is read-write and resets to zero
// - previous-result register is read-only and resets to zero
// - at start of conversion previous takes filter if source bit set, else result
// - shift field divides the accumulation by two to the shift, values 1 to 6
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

module adcs_regs
	import adcs_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int RES_W  = 10
) (
	// clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// conversion trigger and converter clock tick
	input  wire logic              trigger,
	input  wire logic              adc_tick,
	// converter core
	output adcs_analog_cfg_t       analog_cfg,
	output adcs_core_ctl_t         core_ctl,
	input  wire logic              core_done,
	input  wire logic [RES_W-1:0]  core_data,
	// computation events
	output logic                   threshold_check
);

	// ==========================================================================
	// state
	typedef enum logic [1:0] {S_IDLE, S_PRE, S_ACQ, S_CONV} adcs_state_t;

	logic [7:0]       ref_q, acq_q, cap_q, pre_q, chan_q, rpt_q, cnt_q;
	logic [15:0]      res_q, prev_q, acc_q, flt_q;
	logic [2:0]       mode_q, shift_q;
	logic             prev_src_q, justify_q;
	logic [7:0]       timer_q;
	adcs_state_t      state_q;
	logic             wr_en, rd_en, go_wr, start, clear_wr;
	logic [11:0]      idx;
	logic [15:0]      res_fmt, acc_next, sample;
	logic             repeat_mode;

	assign idx      = paddr[13:2];
	assign wr_en    = ce && psel && penable && pwrite;
	// read data is loaded in the setup cycle, so it already stands at the access edge where pready is seen
	assign rd_en    = ce && psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign go_wr    = wr_en && (idx == IDX_COMPUTE_CONTROL) && pwdata[CTRL_GO_BIT];
	assign clear_wr = wr_en && (idx == IDX_COMPUTE_CONTROL) && pwdata[CTRL_CLEAR_BIT];
	assign start    = ce && (state_q == S_IDLE) && (trigger || go_wr);
	assign repeat_mode = (mode_q == MODE_AVERAGE) || (mode_q == MODE_BURST) || (mode_q == MODE_LOWPASS);

	// address is mapped when it names one of the words of the set
	function automatic logic is_mapped(input logic [11:0] i);
		is_mapped = (i == IDX_REFERENCE_SELECT) || (i == IDX_ACQUISITION_TIME) ||
			(i == IDX_EXTRA_SAMPLE_CAP) || (i == IDX_PRECHARGE_TIME) ||
			(i == IDX_POS_CHANNEL_SELECT) || (i == IDX_PREVIOUS_RESULT) ||
			(i == IDX_CONVERSION_RESULT) || (i == IDX_REPEAT_THRESHOLD) ||
			(i == IDX_REPEAT_COUNTER) || (i == IDX_FILTER_OUTPUT) ||
			(i == IDX_COMPUTE_CONTROL) || (i == IDX_SEQUENCE_STATUS);
	endfunction

	// ==========================================================================
	// result formatting and accumulator step
	always_comb begin
		if (justify_q) begin
			res_fmt = {6'h00, core_data};
		end else begin
			res_fmt = {core_data, 6'h00};
		end
	end

	assign sample = {6'h00, core_data};

	// lowpass keeps the scaled filter state: acc += x - acc/2^shift, giving unity gain
	always_comb begin
		if (mode_q == MODE_LOWPASS) begin
			acc_next = acc_q + sample - (acc_q >> shift_q);
		end else if ((mode_q == MODE_AVERAGE) && (cnt_q == rpt_q)) begin
			acc_next = sample;  // average restarts its sum with the sample of the conversion that fires each check
		end else begin
			acc_next = acc_q + sample;
		end
	end

	// ==========================================================================
	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q      <= RST_BYTE;
			acq_q      <= RST_BYTE;
			cap_q      <= RST_BYTE;
			pre_q      <= RST_BYTE;
			chan_q     <= RST_BYTE;
			rpt_q      <= RST_BYTE;
			mode_q     <= MODE_BASIC;
			shift_q    <= 3'h0;
			prev_src_q <= 1'b0;
			justify_q  <= 1'b0;
		end else if (wr_en) begin
			if (idx == IDX_REFERENCE_SELECT) begin
				ref_q <= {3'h0, pwdata[NEG_REF_BIT], 2'h0, pwdata[POS_REF_LSB +: 2]};
			end else if (idx == IDX_ACQUISITION_TIME) begin
				acq_q <= pwdata[7:0];
			end else if (idx == IDX_EXTRA_SAMPLE_CAP) begin
				cap_q <= {3'h0, pwdata[CAP_W-1:0]};
			end else if (idx == IDX_PRECHARGE_TIME) begin
				pre_q <= pwdata[7:0];
			end else if (idx == IDX_POS_CHANNEL_SELECT) begin
				chan_q <= {2'h0, pwdata[CHANNEL_W-1:0]};
			end else if (idx == IDX_REPEAT_THRESHOLD) begin
				rpt_q <= pwdata[7:0];
			end else if (idx == IDX_COMPUTE_CONTROL) begin
				mode_q     <= pwdata[CTRL_MODE_LSB +: 3];
				shift_q    <= pwdata[CTRL_SHIFT_LSB +: 3];
				prev_src_q <= pwdata[CTRL_PREV_BIT];
				justify_q  <= pwdata[CTRL_JUSTIFY_BIT];
			end
		end
	end

	// analog settings go straight to the core
	always_comb begin
		analog_cfg.neg_ref_select     = ref_q[NEG_REF_BIT];
		analog_cfg.pos_ref_select     = ref_q[POS_REF_LSB +: 2];
		analog_cfg.pos_channel_select = chan_q[CHANNEL_W-1:0];
		analog_cfg.extra_cap_pf       = cap_q[CAP_W-1:0];
	end

	// ==========================================================================
	// sequencer: precharge, acquisition, conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			timer_q <= RST_BYTE;
		end else if (ce) begin
			case (state_q)
				S_IDLE: begin
					if (start) begin
						if (pre_q != RST_BYTE) begin
							state_q <= S_PRE;
							timer_q <= pre_q;
						end else if (acq_q != RST_BYTE) begin
							state_q <= S_ACQ;
							timer_q <= acq_q;
						end else begin
							state_q <= S_CONV;
						end
					end
				end
				S_PRE: begin
					if (adc_tick && (timer_q == CNT_ONE)) begin
						if (acq_q != RST_BYTE) begin
							state_q <= S_ACQ;
							timer_q <= acq_q;
						end else begin
							state_q <= S_CONV;
						end
					end else if (adc_tick) begin
						timer_q <= timer_q - CNT_ONE;
					end
				end
				S_ACQ: begin
					if (adc_tick && (timer_q == CNT_ONE)) begin
						state_q <= S_CONV;
					end else if (adc_tick) begin
						timer_q <= timer_q - CNT_ONE;
					end
				end
				S_CONV: begin
					if (core_done) begin
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		core_ctl.precharge     = (state_q == S_PRE);
		core_ctl.acquire       = (state_q == S_ACQ);
		core_ctl.convert_start = (state_q == S_CONV);
	end

	// ==========================================================================
	// result and previous result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q  <= RST_WORD;
			prev_q <= RST_WORD;
		end else if (ce) begin
			if (wr_en && (idx == IDX_CONVERSION_RESULT)) begin
				res_q <= pwdata[15:0];
			end
			if ((state_q == S_CONV) && core_done) begin
				res_q <= res_fmt;  // hardware result wins over a same-cycle write
			end
			if (start) begin
				prev_q <= prev_src_q ? flt_q : res_q;
			end
		end
	end

	// ==========================================================================
	// repeat counter, accumulator and filter output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q           <= RST_BYTE;
			acc_q           <= RST_WORD;
			flt_q           <= RST_WORD;
			threshold_check <= 1'b0;
		end else if (ce) begin
			threshold_check <= 1'b0;
			if (wr_en && (idx == IDX_REPEAT_COUNTER)) begin
				cnt_q <= pwdata[7:0];
			end
			if (clear_wr) begin
				cnt_q <= RST_BYTE;
				acc_q <= RST_WORD;
			end
			if ((state_q == S_CONV) && core_done && (mode_q != MODE_BASIC)) begin
				acc_q <= acc_next;
				flt_q <= acc_next >> shift_q;
				if (repeat_mode) begin
					if (cnt_q == rpt_q) begin
						threshold_check <= 1'b1;
						cnt_q           <= CNT_ONE;
					end else begin
						cnt_q <= cnt_q + CNT_ONE;
					end
				end
			end
		end
	end

	// ==========================================================================
	// apb read data and error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			if (idx == IDX_REFERENCE_SELECT) begin
				prdata <= {24'h00_0000, ref_q};
			end else if (idx == IDX_ACQUISITION_TIME) begin
				prdata <= {24'h00_0000, acq_q};
			end else if (idx == IDX_EXTRA_SAMPLE_CAP) begin
				prdata <= {24'h00_0000, cap_q};
			end else if (idx == IDX_PRECHARGE_TIME) begin
				prdata <= {24'h00_0000, pre_q};
			end else if (idx == IDX_POS_CHANNEL_SELECT) begin
				prdata <= {24'h00_0000, chan_q};
			end else if (idx == IDX_PREVIOUS_RESULT) begin
				prdata <= {16'h0000, prev_q};
			end else if (idx == IDX_CONVERSION_RESULT) begin
				prdata <= {16'h0000, res_q};
			end else if (idx == IDX_REPEAT_THRESHOLD) begin
				prdata <= {24'h00_0000, rpt_q};
			end else if (idx == IDX_REPEAT_COUNTER) begin
				prdata <= {24'h00_0000, cnt_q};
			end else if (idx == IDX_FILTER_OUTPUT) begin
				prdata <= {16'h0000, flt_q};
			end else if (idx == IDX_COMPUTE_CONTROL) begin
				prdata <= {22'h00_0000, (state_q != S_IDLE), justify_q, prev_src_q, shift_q, 1'b0, mode_q};
			end else if (idx == IDX_SEQUENCE_STATUS) begin
				prdata <= {29'h0000_0000, (state_q == S_PRE) ? PH_PRECHARGE :
					(state_q == S_ACQ) ? PH_ACQUIRE : (state_q == S_CONV) ? PH_CONVERT : PH_IDLE};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	assign pslverr = psel && penable && !is_mapped(idx);

endmodule

// File: verif/adcs_core_model.sv
// partner: converter core answering each convert request after a short or long delay
`timescale 1ns/1ps
module adcs_core_model
	import adcs_pkg::*;
(
	// clock, reset, answer speed
	input wire logic       pclk, presetn, slow,
	// request and reply
	input wire adcs_core_ctl_t ctl,
	input wire logic [9:0] value,
	output logic           done,
	output logic [9:0]     data
);
	logic [2:0] wait_q;
	// ==========================================================================
	// one reply per request; data is only valid in the reply cycle, so it toggles otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 3'h0;
			done   <= 1'b0;
			data   <= 10'h000;
		end else begin
			done <= 1'b0;
			data <= ~data;
			if (ctl.convert_start && !done) begin
				wait_q <= wait_q + 3'h1;
				if (wait_q == (slow ? 3'h4 : 3'h0)) begin
					done   <= 1'b1;
					data   <= value;
					wait_q <= 3'h0;
				end
			end
		end
	end
endmodule

// File: verif/adcs_regs_assertions.sv
// checker: phase timing, reference routing and repeat-check assertions
`timescale 1ns/1ps
module adcs_regs_assertions
	import adcs_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int RES_W  = 10
) (
	// watched ports
	input wire logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata, prdata,
	input wire logic              trigger, adc_tick, core_done, threshold_check,
	input wire logic [RES_W-1:0]  core_data,
	input wire adcs_analog_cfg_t  analog_cfg,
	input wire adcs_core_ctl_t    core_ctl
);
	logic [7:0] pre_q, acq_q, pcnt_q, acnt_q;
	logic [2:0] mode_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================================
	// accepted write to one register index
	sequence s_wr(idx);
		psel && penable && pwrite && ce && paddr[13:2] == idx;
	endsequence
	// shadow of phase lengths and mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q  <= 8'h00;
			acq_q  <= 8'h00;
			mode_q <= 3'h0;
		end else if (psel && penable && pwrite && ce) begin
			if (paddr[13:2] == IDX_PRECHARGE_TIME) pre_q <= pwdata[7:0];
			if (paddr[13:2] == IDX_ACQUISITION_TIME) acq_q <= pwdata[7:0];
			if (paddr[13:2] == IDX_COMPUTE_CONTROL) mode_q <= pwdata[2:0];
		end
	end
	// converter ticks seen inside each phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcnt_q <= 8'h00;
			acnt_q <= 8'h00;
		end else begin
			pcnt_q <= core_ctl.precharge ? pcnt_q + 8'(adc_tick & ce) : 8'h00;
			acnt_q <= core_ctl.acquire ? acnt_q + 8'(adc_tick & ce) : 8'h00;
		end
	end
	// ==========================================================================
	// assertions
	a_neg_ref_route: assert property (s_wr(IDX_REFERENCE_SELECT) |=> analog_cfg.neg_ref_select == $past(pwdata[4]))
		else $error("low reference routing wrong");
	a_pos_ref_route: assert property (s_wr(IDX_REFERENCE_SELECT) |=> analog_cfg.pos_ref_select == $past(pwdata[1:0]))
		else $error("high reference routing wrong");
	a_pre_length: assert property ($fell(core_ctl.precharge) |-> pcnt_q == pre_q)
		else $error("precharge length wrong");
	a_pre_skipped: assert property (core_ctl.precharge |-> pre_q != 8'h00)
		else $error("precharge with zero length");
	a_acq_length: assert property ($fell(core_ctl.acquire) |-> acnt_q == acq_q)
		else $error("acquisition length wrong");
	a_acq_skipped: assert property (core_ctl.acquire |-> acq_q != 8'h00)
		else $error("acquisition with zero length");
	a_check_after_done: assert property (threshold_check |-> $past(core_done) ##1 !threshold_check)
		else $error("threshold check pulse misplaced");
	a_check_mode: assert property (threshold_check |-> mode_q inside {MODE_AVERAGE, MODE_BURST, MODE_LOWPASS})
		else $error("threshold check in wrong mode");
endmodule
bind adcs_regs adcs_regs_assertions #(.ADDR_W(ADDR_W), .RES_W(RES_W)) u_chk (.pclk(pclk), .presetn(presetn),
	.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .trigger(trigger), .adc_tick(adc_tick), .core_done(core_done),
	.threshold_check(threshold_check), .core_data(core_data), .analog_cfg(analog_cfg), .core_ctl(core_ctl));

// File: verif/tb.sv
// testbench: register access, conversion phases and computation modes
`timescale 1ns/1ps
module tb
	import adcs_pkg::*;
;
	// ==========================================================================
	// signals and bench state
	logic             pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, slverr;
	logic             trigger, adc_tick, core_done, threshold_check, slow;
	logic [15:0]      paddr;
	logic [31:0]      pwdata, prdata, rd, v, acc, prev;
	logic [9:0]       core_data, conv_val;
	adcs_analog_cfg_t analog_cfg;
	adcs_core_ctl_t   core_ctl;
	int               errors, checks_done, pulses;
	localparam logic [11:0] CFG [7] = '{IDX_REFERENCE_SELECT, IDX_ACQUISITION_TIME, IDX_EXTRA_SAMPLE_CAP,
		IDX_PRECHARGE_TIME, IDX_POS_CHANNEL_SELECT, IDX_REPEAT_THRESHOLD, IDX_REPEAT_COUNTER};
	localparam logic [31:0] MSK [7] = '{32'h0000_0013, 32'h0000_00ff, 32'h0000_001f, 32'h0000_00ff,
		32'h0000_003f, 32'h0000_00ff, 32'h0000_00ff};
	localparam logic [7:0] PRE [6] = '{8'h00, 8'h01, 8'h00, 8'h03, 8'hff, 8'h01};
	localparam logic [7:0] ACQ [6] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h01, 8'hff};
	adcs_regs uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger(trigger),
		.adc_tick(adc_tick), .analog_cfg(analog_cfg), .core_ctl(core_ctl), .core_done(core_done),
		.core_data(core_data), .threshold_check(threshold_check));
	adcs_core_model core (.pclk(pclk), .presetn(presetn), .slow(slow), .ctl(core_ctl), .value(conv_val),
		.done(core_done), .data(core_data));
	// clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// random converter ticks, count of threshold pulses
	always @(posedge pclk) begin
		adc_tick <= 1'($urandom % 2);
		if (threshold_check === 1'b1) pulses++;
	end
	// ==========================================================================
	// tasks and expectations
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		slverr = pslverr;
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic conv(input logic [9:0] d);
		conv_val <= d;
		trigger  <= 1'b1;
		@(posedge pclk);
		trigger  <= 1'b0;
		for (int n = 0; n < 3000 && core_done !== 1'b1; n++) @(posedge pclk);
		if (core_done !== 1'b1) errors++;
		repeat (2) @(posedge pclk);
	endtask
	function automatic logic [31:0] just(input logic right, input logic [9:0] d);
		return right ? {22'h0, d} : {16'h0, d, 6'h00};
	endfunction
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#500_000;
		errors++;
		finish_test();
	end
	// ==========================================================================
	// main sequence
	initial begin
		errors = 0;
		checks_done = 0;
		pulses = 0;
		{ce, presetn, psel, penable, pwrite, trigger, adc_tick, slow} = 8'h80;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		conv_val = 10'h000;
		v = $urandom(18);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (CFG[i]) rdchk(CFG[i], 32'h0000_0000);
		rdchk(IDX_CONVERSION_RESULT, 32'h0000_0000);
		rdchk(IDX_PREVIOUS_RESULT, 32'h0000_0000);
		foreach (CFG[i]) begin
			v = $urandom;
			apb(1'b1, CFG[i], v);
			rdchk(CFG[i], v & MSK[i]);
		end
		for (int k = 0; k < 8; k++) begin
			v = (k == 7) ? 32'h0000_001f : $urandom;
			apb(1'b1, IDX_REFERENCE_SELECT, {27'h0, k[2], 2'h0, k[1:0]});
			apb(1'b1, IDX_POS_CHANNEL_SELECT, v);
			apb(1'b1, IDX_EXTRA_SAMPLE_CAP, v);
			chk(32'(analog_cfg.neg_ref_select), 32'(k[2]));
			chk(32'(analog_cfg.pos_ref_select), 32'(k[1:0]));
			chk(32'(analog_cfg.pos_channel_select), v & 32'h3f);
			chk(32'(analog_cfg.extra_cap_pf), v & 32'h1f);
		end
		apb(1'b1, IDX_PREVIOUS_RESULT, 32'hffff_ffff);
		rdchk(IDX_PREVIOUS_RESULT, 32'h0000_0000);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(32'(slverr), 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, IDX_REPEAT_THRESHOLD, 32'h0000_0002);
		ce <= 1'b0;
		apb(1'b1, IDX_REPEAT_THRESHOLD, 32'h0000_0055);
		ce <= 1'b1;
		rdchk(IDX_REPEAT_THRESHOLD, 32'h0000_0002);
		apb(1'b1, IDX_CONVERSION_RESULT, 32'h0000_a5c3);
		rdchk(IDX_CONVERSION_RESULT, 32'h0000_a5c3);
		prev = 32'h0000_a5c3;
		$display("test registers done");
		foreach (PRE[i]) begin
			slow <= i[0];
			apb(1'b1, IDX_COMPUTE_CONTROL, {23'h0, i[0], 8'h00});
			apb(1'b1, IDX_PRECHARGE_TIME, {24'h0, PRE[i]});
			apb(1'b1, IDX_ACQUISITION_TIME, {24'h0, ACQ[i]});
			conv(10'($urandom));
			rdchk(IDX_PREVIOUS_RESULT, prev);
			prev = just(i[0], conv_val);
			rdchk(IDX_CONVERSION_RESULT, prev);
		end
		$display("test phases done");
		apb(1'b1, IDX_PRECHARGE_TIME, 32'h0000_0001);
		apb(1'b1, IDX_ACQUISITION_TIME, 32'h0000_0001);
		for (int s = 1; s < 7; s++) begin
			apb(1'b1, IDX_COMPUTE_CONTROL, 32'h0000_0109 | 32'(s << 4));
			acc = 32'h0000_0000;
			repeat (3) begin
				conv(10'($urandom));
				acc += 32'(conv_val);
				rdchk(IDX_FILTER_OUTPUT, acc >> s);
			end
		end
		apb(1'b1, IDX_COMPUTE_CONTROL, 32'h0000_01e1);
		conv(10'h155);
		rdchk(IDX_PREVIOUS_RESULT, acc >> 6);
		$display("test accumulate done");
		for (int m = 2; m < 5; m++) begin
			pulses = 0;
			acc = 32'h0000_0000;
			apb(1'b1, IDX_COMPUTE_CONTROL, 32'h0000_0118 | 32'(m));
			for (int n = 1; n < 4; n++) begin
				conv(10'($urandom));
				acc = acc + 32'(conv_val) - (acc >> 1);
				rdchk(IDX_REPEAT_COUNTER, (n == 3) ? 32'h0000_0001 : 32'(n));
				if (m == 4) rdchk(IDX_FILTER_OUTPUT, acc >> 1);
			end
			chk(32'(pulses), 32'h0000_0001);
		end
		apb(1'b1, IDX_COMPUTE_CONTROL, 32'h0000_0100);
		conv(10'h2aa);
		rdchk(IDX_REPEAT_COUNTER, 32'h0000_0001);
		chk(32'(pulses), 32'h0000_0001);
		$display("test repeat modes done");
		finish_test();
	end
endmodule
